// file: fep_dev.sv
// flash command interface, erase/program controller and protection logic
// assumes the cpu end issues one access at a time and waits for ack
`timescale 1ns/100ps
module fep_dev (
  // clock and resets
  input  wire logic   clock,
  input  wire logic   rst_n,
  input  wire logic   power_on_rst_n,
  // flash memory interface
  fep_bus_if.dev      bus,
  // status to the system
  output logic        busy,
  output logic        suspended,
  output logic        code_locked
);
  fep_pkg::fep_state_t st, next_st;   // command interface state
  logic [2:0]    cnt, next_cnt;       // writes taken in the current sequence
  logic [15:0]   mem [0:(1<<fep_pkg::AW)-1]; // array, not reset
  logic [15:0]   prot_nv;             // programmed protection value
  logic [15:0]   prot_act;            // value in force since last reset
  logic          prot_loaded;         // prot_act copied after reset release
  logic          blk_unp;             // temporary block unprotection
  logic          code_unp;            // temporary code unprotection
  logic          held;                // an erase is suspended
  logic          fail;                // error flag
  logic          tog;                 // toggle bit state
  logic [7:0]    tmr;                 // suspend/program timer
  logic [fep_pkg::AW-1:0] ers_idx;    // erase sweep word
  logic          ers_ph;              // 0 pre-program, 1 erase
  logic          ers_bad;             // a locked block was met
  logic [15:0]   rdata_q;
  logic          ack_q;
  // strobes from the sequencer
  logic          go_erase, go_prog, go_prot, go_btu, go_abort;

  // access decode
  wire           wr      = bus.req & bus.we;
  wire           rd      = bus.req & ~bus.we;
  wire [7:0]     lo      = bus.wdata[7:0];
  wire [fep_pkg::AW-1:0] widx = bus.addr[fep_pkg::AW:1];
  wire [fep_pkg::BW-1:0] wblk = widx[fep_pkg::AW-1 -: fep_pkg::BW];
  wire [fep_pkg::BW-1:0] eblk = ers_idx[fep_pkg::AW-1 -: fep_pkg::BW];
  wire           odd_w   = bus.addr[1];
  wire           is_unl1 = wr && bus.addr == fep_pkg::ADR_UNL1 && lo == fep_pkg::D_UNL1;
  wire           is_unl2 = wr && bus.addr == fep_pkg::ADR_UNL2 && lo == fep_pkg::D_UNL2;
  wire           is_pu1  = wr && bus.addr == fep_pkg::ADR_PUNL1 && lo == fep_pkg::D_UNL1;
  wire           is_pu2  = wr && bus.addr == fep_pkg::ADR_PUNL2 && lo == fep_pkg::D_UNL2;
  wire           is_rst  = wr && lo == fep_pkg::C_RESET;
  wire           at_u1   = bus.addr == fep_pkg::ADR_UNL1;
  wire           at_p1   = bus.addr == fep_pkg::ADR_PUNL1;
  wire           tmr_end = tmr == 8'h00;
  wire           ers_end = (st == fep_pkg::ST_ERASE) && ers_ph && (&ers_idx);
  // deviations fall back to array read, or to suspend when an erase is held
  wire fep_pkg::fep_state_t home = held ? fep_pkg::ST_SUSP : fep_pkg::ST_IDLE;

  // block lock: protected blocks 0..10 unless temporarily unprotected
  function automatic logic locked(input logic [fep_pkg::BW-1:0] b);
    locked = (b < fep_pkg::BW'(fep_pkg::PROT_NBLK)) && !prot_act[b] && !blk_unp;
  endfunction

  // program checks: locked block, or a 0 to 1 change that cannot be made
  wire prog_bad  = locked(wblk) || |(~mem[widx] & bus.wdata);
  wire ers_write = (st == fep_pkg::ST_ERASE) && !locked(eblk);
  wire code_prot = !prot_act[fep_pkg::PROT_CODE] && !code_unp;

  // sequencer: next state and strobes
  always_comb begin
    next_st  = st;
    next_cnt = cnt;
    go_erase = 1'b0;
    go_prog  = 1'b0;
    go_prot  = 1'b0;
    go_btu   = 1'b0;
    go_abort = 1'b0;
    case (st)
      fep_pkg::ST_IDLE: begin
        next_cnt = 3'd1;
        if (is_unl1) next_st = fep_pkg::ST_UNL_A;
        else if (is_pu1) next_st = fep_pkg::ST_PUNL_A;
      end
      fep_pkg::ST_UNL_A: if (wr) begin                       // second unlock write
        next_st  = is_unl2 ? fep_pkg::ST_UNL_B : home;
        next_cnt = cnt + 3'd1;
      end
      fep_pkg::ST_UNL_B: if (wr) begin                       // command cycle 3 or 6
        next_st = home;
        if (cnt == 3'd2 && at_u1 && lo == fep_pkg::C_PROG) begin
          next_st = fep_pkg::ST_PRG_WA;
        end else if (cnt == 3'd2 && at_u1 && lo == fep_pkg::C_ERASE_EN && !held) begin
          next_st  = fep_pkg::ST_ARM;
          next_cnt = 3'd3;
        end else if (cnt == 3'd5 && at_u1 && lo == fep_pkg::C_CHIP) begin
          next_st  = fep_pkg::ST_ERASE;
          go_erase = 1'b1;
        end else if (lo == fep_pkg::C_RESET) begin
          // a read/reset behind an unlock pair also drops a held erase
          next_st  = fep_pkg::ST_IDLE;
          go_abort = held;
        end
      end
      fep_pkg::ST_ARM: if (wr) begin                         // second unlock pair
        next_st  = is_unl1 ? fep_pkg::ST_UNL_A : fep_pkg::ST_IDLE;
        next_cnt = cnt + 3'd1;
      end
      fep_pkg::ST_PRG_WA: if (wr) begin
        // a held erase keeps its block closed to programming
        if (held && wblk == eblk) next_st = fep_pkg::ST_SUSP;
        else begin
          next_st = fep_pkg::ST_PROG;
          go_prog = 1'b1;
        end
      end
      fep_pkg::ST_PROG: if (tmr_end) next_st = home;
      fep_pkg::ST_PUNL_A: if (wr) next_st = is_pu2 ? fep_pkg::ST_PUNL_B : fep_pkg::ST_IDLE;
      fep_pkg::ST_PUNL_B: if (wr) begin
        next_st = fep_pkg::ST_IDLE;
        if (at_p1 && lo == fep_pkg::C_PROT_PRG) next_st = fep_pkg::ST_SP_DAT;
        else if (at_p1 && lo == fep_pkg::C_PROT_RD) next_st = fep_pkg::ST_RP;
        else if (at_p1 && lo == fep_pkg::C_BLK_UNP) next_st = fep_pkg::ST_BTU;
      end
      fep_pkg::ST_SP_DAT: if (wr) begin
        next_st = fep_pkg::ST_IDLE;
        go_prot = odd_w;
      end
      fep_pkg::ST_RP: if (is_rst) next_st = fep_pkg::ST_IDLE;
      fep_pkg::ST_BTU: if (wr) begin
        next_st = fep_pkg::ST_IDLE;
        go_btu  = is_rst;
      end
      fep_pkg::ST_ERASE: begin
        if (wr && lo == fep_pkg::C_PAUSE) next_st = fep_pkg::ST_SWAIT;
        else if (is_rst) begin
          next_st  = fep_pkg::ST_IDLE;
          go_abort = 1'b1;
        end else if (ers_end) next_st = fep_pkg::ST_IDLE;
      end
      fep_pkg::ST_SWAIT: begin
        if (is_rst) begin
          next_st  = fep_pkg::ST_IDLE;
          go_abort = 1'b1;
        end else if (tmr_end) next_st = fep_pkg::ST_SUSP;
      end
      fep_pkg::ST_SUSP: begin
        next_cnt = 3'd1;
        if (is_unl1) next_st = fep_pkg::ST_UNL_A;
        else if (wr && lo == fep_pkg::C_CONTINUE) next_st = fep_pkg::ST_ERASE;
        else if (is_rst) begin
          next_st  = fep_pkg::ST_IDLE;
          go_abort = 1'b1;
        end
      end
      default: next_st = fep_pkg::ST_IDLE;
    endcase
  end

  // state and sequence counter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st  <= fep_pkg::ST_IDLE;
      cnt <= 3'd0;
    end else begin
      st  <= next_st;
      cnt <= next_cnt;
    end
  end

  // one timer serves the suspend latency and the program busy time
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) tmr <= 8'h00;
    else if (wr && st == fep_pkg::ST_ERASE && lo == fep_pkg::C_PAUSE) tmr <= fep_pkg::TMR_SUSP;
    else if (go_prog) tmr <= fep_pkg::TMR_PROG;
    else if (!tmr_end) tmr <= tmr - 8'h01;
  end

  // suspend flag: only a reset write or resume lets the held erase go
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) held <= 1'b0;
    else if (go_abort || next_st == fep_pkg::ST_ERASE) held <= 1'b0;
    else if (st == fep_pkg::ST_SWAIT && tmr_end) held <= 1'b1;
  end

  // erase sweep: every unlocked word to 0000h, then every unlocked word to FFFFh
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ers_idx <= '0;
      ers_ph  <= 1'b0;
      ers_bad <= 1'b0;
    end else if (go_erase) begin
      ers_idx <= '0;
      ers_ph  <= 1'b0;
      ers_bad <= 1'b0;
    end else if (st == fep_pkg::ST_ERASE && !ers_end) begin
      ers_idx <= ers_idx + 1'b1;
      if (&ers_idx) ers_ph <= 1'b1;
      if (locked(eblk)) ers_bad <= 1'b1;
    end
  end

  // array write port; a locked block never changes
  always_ff @(posedge clock) begin
    if (ers_write) mem[ers_idx] <= ers_ph ? fep_pkg::D_ERASED : fep_pkg::D_PREPROG;
    else if (go_prog && !locked(wblk)) mem[widx] <= mem[widx] & bus.wdata;
  end

  // error flag: held until a reset write clears the controller
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) fail <= 1'b0;
    else if (ers_end && (ers_bad || locked(eblk))) fail <= 1'b1;
    else if (go_prog && prog_bad) fail <= 1'b1;
    else if (is_rst) fail <= 1'b0;
  end

  // protection value: bits only ever go to 0, hence no user clear
  always_ff @(posedge clock or negedge power_on_rst_n) begin
    if (!power_on_rst_n) prot_nv <= fep_pkg::PROT_RESET;
    else if (go_prot) prot_nv <= prot_nv & bus.wdata;
  end

  // in-force copy taken once after reset release, so new values wait a reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prot_act    <= fep_pkg::PROT_RESET;
      prot_loaded <= 1'b0;
    end else if (!prot_loaded) begin
      prot_act    <= prot_nv;
      prot_loaded <= 1'b1;
    end
  end

  // temporary unprotection flags, both cleared by system reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      blk_unp  <= 1'b0;
      code_unp <= 1'b0;
    end else begin
      if (go_btu) blk_unp <= 1'b1;
      // writes from outside the flash are ignored here
      if (wr && bus.from_flash && st == fep_pkg::ST_IDLE) begin
        if (bus.wdata == fep_pkg::D_CODE_UNP) code_unp <= 1'b1;
        else if (bus.wdata == fep_pkg::D_CODE_REP) code_unp <= 1'b0;
      end
    end
  end

  // read path selection
  wire run6     = st == fep_pkg::ST_ERASE || st == fep_pkg::ST_SWAIT || st == fep_pkg::ST_PROG;
  wire in_eblk  = st == fep_pkg::ST_SUSP && wblk == eblk;
  wire stat_rd  = run6 || fail || in_eblk;
  wire [15:0] stat_word = {8'h00, 1'b0, tog & run6, fail, 1'b0,
                           held || st == fep_pkg::ST_ERASE || st == fep_pkg::ST_SWAIT,
                           tog & (run6 || held), 2'b00};
  // when idle after a good erase the array reads FFFFh, so the poll bit is 1
  wire [15:0] rd_val = (code_prot && !bus.from_flash) ? fep_pkg::D_TRAP :
                       (st == fep_pkg::ST_RP && odd_w) ? prot_act :
                       stat_rd ? stat_word :
                       mem[widx];

  // toggle flips on each status read while work is under way
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) tog <= 1'b0;
    else if (rd && stat_rd && (run6 || held) && !fail) tog <= ~tog;
  end

  // answer every access one cycle later
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_q   <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      ack_q <= bus.req;
      if (rd) rdata_q <= rd_val;
    end
  end

  assign bus.ack     = ack_q;
  assign bus.rdata   = rdata_q;
  assign busy        = run6;
  assign suspended   = held;
  assign code_locked = code_prot;
endmodule // fep_dev

// file: fep_pkg.sv
// constants, command codes, states and register map shared by both ends
// assumes one 200 MHz clock; addresses are the cpu's 16-bit byte addresses
//
// What this block does
// - chip erase: unlock, 80h@1554h, unlock, 10h
// - wrong sequence cycle returns to array read, or to suspend while an erase is held
// - controller pre-programs 0000h, then erases FFFFh
// - reads return status once controller runs
// - poll bit 0 while erasing, 1 after a good erase
// - both toggle bits flip per read while running, only bit 2 while suspended; stop after
// - error bit on failure; read/reset clears it
// - B0h anywhere, no unlock, suspends erase
// - suspend takes effect within 0.1 to 15 us
// - suspended: other blocks array, erasing block status
// - suspend accepts resume, program; reset aborts erase
// - 30h anywhere resumes suspended erase
// - suspend program only outside the erasing block
// - protection program: zero bit protects block/code
// - protection bits sticky, active after next reset
// - host rewrites zero for already-zero protection bits
// - 90h@2A54h: odd word reads give protection until F0h
// - C1h then F0h unprotects all blocks until reset
// - protected code read from outside returns 009Bh
// - 7FFFh at odd word sets code protection
// - FFFFh from flash lifts code protection until reset
// - FFFBh from flash restores code protection
// - unlock pair: A8h@1554h then 54h@2AA8h
package fep_pkg;
  // command interface addresses and data codes (low byte only, except the 16-bit code protection words)
  localparam logic [15:0] ADR_UNL1   = 16'h1554;
  localparam logic [15:0] ADR_UNL2   = 16'h2AA8;
  localparam logic [15:0] ADR_PUNL1  = 16'h2A54;
  localparam logic [15:0] ADR_PUNL2  = 16'h15A8;
  localparam logic [7:0]  D_UNL1     = 8'hA8;
  localparam logic [7:0]  D_UNL2     = 8'h54;
  localparam logic [7:0]  C_ERASE_EN = 8'h80;
  localparam logic [7:0]  C_CHIP     = 8'h10;
  localparam logic [7:0]  C_PROG     = 8'hA0;
  localparam logic [7:0]  C_PAUSE    = 8'hB0;
  localparam logic [7:0]  C_CONTINUE = 8'h30;
  localparam logic [7:0]  C_RESET    = 8'hF0;
  localparam logic [7:0]  C_PROT_PRG = 8'hC0;
  localparam logic [7:0]  C_PROT_RD  = 8'h90;
  localparam logic [7:0]  C_BLK_UNP  = 8'hC1;
  localparam logic [15:0] D_CODE_UNP = 16'hFFFF;
  localparam logic [15:0] D_CODE_REP = 16'hFFFB;
  localparam logic [15:0] D_TRAP     = 16'h009B;
  localparam logic [15:0] D_ERASED   = 16'hFFFF;
  localparam logic [15:0] D_PREPROG  = 16'h0000;
  // protection register layout
  localparam logic [15:0] PROT_RESET = 16'hFFFF;
  localparam int          PROT_NBLK  = 11;
  localparam int          PROT_CODE  = 15;
  // status word bit positions
  localparam int SB_POLL = 7;
  localparam int SB_TOG6 = 6;
  localparam int SB_ERR  = 5;
  localparam int SB_TMR  = 3;
  localparam int SB_TOG2 = 2;
  // array: 2048 words in 16 blocks of 128 words
  localparam int AW = 11;
  localparam int BW = 4;
  // timing
  localparam int CLK_PS        = 5000;
  localparam int SUSP_MIN_PS   = 100;
  localparam int SUSP_MAX_PS   = 15000000;
  localparam int SUSP_CYC      = (SUSP_MIN_PS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam logic [7:0] TMR_SUSP = 8'(SUSP_CYC - 1);
  localparam logic [7:0] TMR_PROG = 8'h0F;
  // command interface states, one-hot
  typedef enum logic [13:0] {
    ST_IDLE   = 14'h0001, ST_UNL_A  = 14'h0002, ST_UNL_B  = 14'h0004,
    ST_ARM    = 14'h0008, ST_PRG_WA = 14'h0010, ST_PROG   = 14'h0020,
    ST_PUNL_A = 14'h0040, ST_PUNL_B = 14'h0080, ST_SP_DAT = 14'h0100,
    ST_RP     = 14'h0200, ST_BTU    = 14'h0400, ST_ERASE  = 14'h0800,
    ST_SWAIT  = 14'h1000, ST_SUSP   = 14'h2000
  } fep_state_t;
  // host controller register map (axi4-lite byte offsets)
  localparam logic [3:0] REG_ADDR  = 4'h0;
  localparam logic [3:0] REG_WDATA = 4'h4;
  localparam logic [3:0] REG_CTRL  = 4'h8;
  localparam logic [3:0] REG_STAT  = 4'hC;
  localparam int CTRL_GO   = 0;
  localparam int CTRL_WR   = 1;
  localparam int CTRL_INFL = 2;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// file: fep_bus_if.sv
// flash memory interface between the cpu end and the flash command logic
// assumes both ends share one clock; the testbench instantiates it
`timescale 1ns/100ps
interface fep_bus_if;
  logic        req;        // one-cycle access strobe
  logic        we;         // 1 write, 0 read
  logic        from_flash; // access issued by code running in the flash
  logic [15:0] addr;       // byte address
  logic [15:0] wdata;      // write data
  logic        ack;        // one-cycle answer
  logic [15:0] rdata;      // read data, valid with ack
  modport dev (input req, we, from_flash, addr, wdata, output ack, rdata);
  modport cpu (output req, we, from_flash, addr, wdata, input ack, rdata);
endinterface // fep_bus_if

// file: fep_cpu.sv
// cpu end: turns axi4-lite register writes into flash access cycles
// assumes software sequences the commands; one access is in flight at a time
`timescale 1ns/100ps
module fep_cpu (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // axi4-lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // flash memory interface
  fep_bus_if.cpu           bus
);
  logic [3:0]  aw_q;        // held write address
  logic [31:0] w_q;         // held write data
  logic        aw_ok, w_ok; // channel taken
  logic [15:0] addr_r, wdata_r, rd_r;
  logic [2:0]  ctrl_r;      // last control word
  logic        busy, req_q;

  // write side: take address and data in any order, answer after both
  assign s_axi_awready = !aw_ok && !s_axi_bvalid;
  assign s_axi_wready  = !w_ok && !s_axi_bvalid;
  wire do_wr  = aw_ok && w_ok && !s_axi_bvalid;
  wire wr_map = aw_q[1:0] == 2'b00 && aw_q != fep_pkg::REG_STAT;
  wire go     = do_wr && aw_q == fep_pkg::REG_CTRL && w_q[fep_pkg::CTRL_GO] && !busy;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_ok <= 1'b0;
      w_ok  <= 1'b0;
      aw_q  <= 4'h0;
      w_q   <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok <= 1'b1;
        aw_q  <= s_axi_awaddr;
      end else if (do_wr) aw_ok <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok <= 1'b1;
        w_q  <= s_axi_wdata;
      end else if (do_wr) w_ok <= 1'b0;
    end
  end

  // response and register updates; a write while busy is dropped but answered
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= fep_pkg::RESP_OK;
      addr_r       <= 16'h0000;
      wdata_r      <= 16'h0000;
      ctrl_r       <= 3'h0;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_map ? fep_pkg::RESP_OK : fep_pkg::RESP_ERR;
      if (aw_q == fep_pkg::REG_ADDR && !busy) addr_r <= w_q[15:0];
      if (aw_q == fep_pkg::REG_WDATA && !busy) wdata_r <= w_q[15:0];
      if (go) ctrl_r <= w_q[2:0];
    end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
  end

  // flash cycle: one request strobe, then wait for the device answer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy  <= 1'b0;
      req_q <= 1'b0;
      rd_r  <= 16'h0000;
    end else begin
      req_q <= go;
      if (go) busy <= 1'b1;
      else if (bus.ack) begin
        busy <= 1'b0;
        rd_r <= bus.rdata;
      end
    end
  end

  assign bus.req        = req_q;
  assign bus.we         = ctrl_r[fep_pkg::CTRL_WR];
  assign bus.from_flash = ctrl_r[fep_pkg::CTRL_INFL];
  assign bus.addr       = addr_r;
  assign bus.wdata      = wdata_r;

  // read side: one word per request, unmapped offsets answer slverr
  wire [31:0] rd_mux = (s_axi_araddr == fep_pkg::REG_ADDR)  ? {16'h0000, addr_r} :
                       (s_axi_araddr == fep_pkg::REG_WDATA) ? {16'h0000, wdata_r} :
                       (s_axi_araddr == fep_pkg::REG_CTRL)  ? {29'h0, ctrl_r} :
                       {rd_r, 15'h0000, busy};
  wire rd_map = s_axi_araddr[1:0] == 2'b00;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= fep_pkg::RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_map ? rd_mux : 32'h0000_0000;
      s_axi_rresp  <= rd_map ? fep_pkg::RESP_OK : fep_pkg::RESP_ERR;
    end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end
endmodule // fep_cpu

// file: fep_chk.sv
// checks on the flash interface between the two ends
// assumes one clock; the bench instantiates it beside the interface
`timescale 1ns/100ps
module fep_chk (
  // clock, reset and flash interface signals
  input wire logic        clock, rst_n, req, we, from_flash, ack,
  input wire logic [15:0] addr, wdata, rdata
);
  // whole-array erase: six writes of address and low data byte
  localparam logic [143:0] CE = {16'h1554, 8'hA8, 16'h2AA8, 8'h54, 16'h1554, 8'h80,
    16'h1554, 8'hA8, 16'h2AA8, 8'h54, 16'h1554, 8'h10};
  logic [143:0] hist;         // last six writes
  logic [12:0]  cnt;          // cycles since last write, saturating
  logic         armed, rd_q;  // erase begun, read asked last cycle
  logic         pv, p6;       // status read seen in this erase, its toggle bit
  wire  [143:0] next_hist = {hist[119:0], addr, wdata[7:0]};
  wire          wr = req && we;
  wire          rd_ack = ack && rd_q;
  // margins inside the 4096-cycle sweep keep clear of its ends
  wire          run_w = armed && cnt < 13'h0FA0;
  wire          done_w = armed && cnt > 13'h1068;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // follow command writes and the erase run
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {hist, cnt, armed, rd_q, pv, p6} <= '0;
    end else begin
      rd_q <= req && !we;
      hist <= wr ? next_hist : hist;
      armed <= wr ? next_hist == CE : armed;
      cnt <= wr ? 13'h0000 : cnt + {12'h000, cnt != 13'h1FFF};
      pv <= !wr && (pv || (rd_ack && run_w));
      p6 <= (rd_ack && run_w) ? rdata[6] : p6;
    end
  end
  ack_follows_a: assert property (req |=> ack) else $error("no answer");
  ack_cause_a: assert property (ack |-> $past(req)) else $error("stray answer");
  ack_pulse_a: assert property ($rose(ack) |=> $fell(ack)) else $error("long answer");
  one_access_a: assert property (req |=> !req) else $error("accesses too close");
  rdata_hold_a: assert property (!(req && !we) |=> $stable(rdata)) else $error("data moved");
  erase_poll_a: assert property (rd_ack && run_w |-> !rdata[7] && rdata[3])
    else $error("status not busy");
  erase_toggle_a: assert property (rd_ack && run_w && pv |-> rdata[6] != p6)
    else $error("toggle stuck");
  erase_done_a: assert property (rd_ack && done_w |-> rdata == 16'hFFFF)
    else $error("word not erased");
  cover property (rd_ack && run_w && pv);
  cover property (wr && wdata[7:0] == 8'hB0);
  cover property (req && !we && !from_flash);
endmodule // fep_chk

// file: flash_erase_protect_commands_test.sv
// bench: both ends joined by the interface, driven through axi4-lite
// assumes the cpu end's register map: addr, wdata, ctrl, stat
`timescale 1ns/100ps
module flash_erase_protect_commands_test;
  logic        clock, rst_n, por_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [3:0]  awaddr, araddr;
  logic [1:0]  bresp;
  logic [31:0] wdat, rdat, s;  // s: last axi answer
  logic [15:0] res;            // last flash read result
  int          failures, checks;
  logic        dbusy, susp, lock; // device status outputs
  fep_bus_if bus_i ();
  fep_dev fep_dev_inst (.clock(clock), .rst_n(rst_n), .power_on_rst_n(por_n),
    .bus(bus_i.dev), .busy(dbusy), .suspended(susp), .code_locked(lock));
  fep_cpu fep_cpu_inst (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdat),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdat),
    .s_axi_rresp(), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus(bus_i.cpu));
  fep_chk fep_chk_inst (.clock(clock), .rst_n(rst_n), .req(bus_i.req), .we(bus_i.we),
    .from_flash(bus_i.from_flash), .addr(bus_i.addr), .wdata(bus_i.wdata),
    .ack(bus_i.ack), .rdata(bus_i.rdata));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // one axi write or read; channels released as each is taken
  task axi(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    {awaddr, araddr, wdat} <= {a, a, d};
    if (w) {awvalid, wvalid, bready} <= 3'h7;
    else {arvalid, rready} <= 2'h3;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
    end while (!(w ? bvalid : rvalid));
    s = w ? {30'h0, bresp} : rdat;
    {bready, rready} <= 2'h0;
  endtask
  // one flash access through the cpu end; waits until it is done
  task acc(input logic w, f, input logic [15:0] a, d);
    axi(1'b1, 4'h0, {16'h0000, a});
    axi(1'b1, 4'h4, {16'h0000, d});
    axi(1'b1, 4'h8, {29'h0, f, w, 1'b1});
    do axi(1'b0, 4'hC, 32'h0); while (s[0] !== 1'b0);
    res = s[31:16];
  endtask
  // unlock pair (ordinary or protection), then one command write
  task cmd(input logic p, input logic [15:0] a, d);
    acc(1'b1, 1'b1, p ? 16'h2A54 : 16'h1554, 16'h00A8);
    acc(1'b1, 1'b1, p ? 16'h15A8 : 16'h2AA8, 16'h0054);
    acc(1'b1, 1'b1, a, d);
  endtask
  task chk(input logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // read and compare the bits under a mask
  task rdc(input logic f, input logic [15:0] a, e, m);
    acc(1'b0, f, a, 16'h0000);
    chk(res & m, e & m);
  endtask
  task prot_rd(input logic [15:0] e);
    cmd(1'b1, 16'h2A54, 16'h0090);
    rdc(1'b1, 16'h0002, e, 16'hFFFF);
    acc(1'b1, 1'b1, 16'h0000, 16'h00F0);
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #300000;
    failures++;
    give_verdict();
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdat} = '0;
    {failures, checks, rst_n, por_n} = '0;
    repeat (8) @(posedge clock);
    {rst_n, por_n} <= 2'h3;
    axi(1'b1, 4'h2, 32'h0);
    chk(s[15:0], 16'h0002);  // unmapped offset gives a slave error
    prot_rd(16'hFFFF);
    cmd(1'b0, 16'h1554, 16'h0080);
    cmd(1'b0, 16'h1554, 16'h0010);
    rdc(1'b1, 16'h0000, 16'h0008, 16'h0088);
    rdc(1'b1, 16'h0000, res ^ 16'h0044, 16'h0044);
    repeat (4300) @(posedge clock);
    rdc(1'b1, 16'h0000, 16'hFFFF, 16'hFFFF);
    cmd(1'b0, 16'h1556, 16'h0080);
    cmd(1'b0, 16'h1554, 16'h0010);
    rdc(1'b1, 16'h0000, 16'hFFFF, 16'hFFFF);
    cmd(1'b0, 16'h1554, 16'h0080);
    cmd(1'b0, 16'h1554, 16'h0010);
    acc(1'b1, 1'b1, 16'h0000, 16'h00B0);
    repeat (40) @(posedge clock);
    rdc(1'b1, 16'h0FFE, 16'hFFFF, 16'hFFFF);
    chk({14'h0, susp, dbusy}, 16'h0002);
    cmd(1'b0, 16'h1554, 16'h00A0);
    acc(1'b1, 1'b1, 16'h0FFE, 16'h1234);
    repeat (40) @(posedge clock);
    rdc(1'b1, 16'h0FFE, 16'h1234, 16'hFFFF);
    cmd(1'b0, 16'h1554, 16'h00A0);
    acc(1'b1, 1'b1, 16'h00FE, 16'h1234);
    chk({14'h0, susp, dbusy}, 16'h0002);
    rdc(1'b1, 16'h00FE, 16'h0008, 16'h0088);
    acc(1'b1, 1'b1, 16'h0000, 16'h0030);
    rdc(1'b1, 16'h0000, 16'h0000, 16'h0080);
    chk({14'h0, susp, dbusy}, 16'h0001);
    repeat (4300) @(posedge clock);
    rdc(1'b1, 16'h0FFE, 16'hFFFF, 16'hFFFF);
    cmd(1'b1, 16'h2A54, 16'h00C0);
    acc(1'b1, 1'b1, 16'h0002, 16'h7FFF);
    prot_rd(16'hFFFF);
    rst_n <= 1'b0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    rdc(1'b0, 16'h0000, 16'h009B, 16'hFFFF);
    chk({15'h0, lock}, 16'h0001);
    prot_rd(16'h7FFF);
    acc(1'b1, 1'b0, 16'h0000, 16'hFFFF);
    rdc(1'b0, 16'h0000, 16'h009B, 16'hFFFF);
    acc(1'b1, 1'b1, 16'h0000, 16'hFFFF);
    chk({15'h0, lock}, 16'h0000);
    rdc(1'b0, 16'h0000, 16'hFFFF, 16'hFFFF);
    acc(1'b1, 1'b1, 16'h0000, 16'hFFFB);
    rdc(1'b0, 16'h0000, 16'h009B, 16'hFFFF);
    cmd(1'b0, 16'h1554, 16'h0080);
    cmd(1'b0, 16'h1554, 16'h0010);
    acc(1'b1, 1'b1, 16'h0000, 16'h00B0);
    repeat (40) @(posedge clock);
    cmd(1'b0, 16'h1554, 16'h00F0);
    chk({14'h0, susp, dbusy}, 16'h0000);
    give_verdict();
  end
endmodule // flash_erase_protect_commands_test
